// ---- tmr_pkg.sv ----
package tmr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h12;
  localparam logic [7:0] OFF_STAT    = 8'h13;
  localparam logic [7:0] OFF_CAP_HI  = 8'h14;
  localparam logic [7:0] OFF_CAP_LO  = 8'h15;
  localparam logic [7:0] OFF_CMP_HI  = 8'h16;
  localparam logic [7:0] OFF_CMP_LO  = 8'h17;
  localparam logic [7:0] OFF_CNT_HI  = 8'h18;
  localparam logic [7:0] OFF_CNT_LO  = 8'h19;
  localparam logic [7:0] OFF_ALT_HI  = 8'h1A;
  localparam logic [7:0] OFF_ALT_LO  = 8'h1B;

  // control register field positions
  localparam int CTL_CAP_IE  = 7;
  localparam int CTL_CMP_IE  = 6;
  localparam int CTL_WRAP_IE = 5;
  localparam int CTL_EOE     = 4;
  localparam int CTL_ECC     = 3;
  localparam int CTL_IEDG    = 1;
  localparam int CTL_OLVL    = 0;
  localparam logic [7:0] CTL_MASK = 8'hFB;

  // flag positions inside the three-bit flag vector (status bits 7..5)
  localparam int FLG_CAP  = 2;
  localparam int FLG_CMP  = 1;
  localparam int FLG_WRAP = 0;
  localparam int STAT_FLG_LSB = 5;

  // reset values and counts
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  localparam int          PRESCALE  = 4;
  localparam int          CLK_MHZ   = 40;
endpackage

// ---- tmr_evt_if.sv ----
`timescale 1ns/1ps
interface tmr_evt_if;
  logic tick;     // one-cycle counter advance strobe
  logic cap_edge; // one-cycle qualifying capture edge
  modport clk_src  (output tick);
  modport edge_src (output cap_edge);
  modport core     (input tick, input cap_edge);
endinterface

// ---- tmr_clk_src.sv ----
`timescale 1ns/1ps
module tmr_clk_src #(
  parameter int DIV = tmr_pkg::PRESCALE
) (
  input  wire logic  clock,
  input  wire logic  nrst,
  input  wire logic  ext_sel,
  input  wire logic  stop_mode,
  input  wire logic  ext_osc,
  tmr_evt_if.clk_src ev
);
  typedef struct packed {
    logic [1:0] div;
    logic       osc_prev;
    logic       tick;
  } tmr_cs_t;

  tmr_cs_t s_r, s_nxt;

  // processor clock path freezes in stop; oscillator path keeps running
  always_comb begin
    s_nxt          = s_r;
    s_nxt.tick     = 1'b0;
    s_nxt.osc_prev = ext_osc;
    if (ext_sel) begin
      s_nxt.tick = ext_osc & ~s_r.osc_prev;
    end else if (!stop_mode) begin
      // wait mode is not gated: counting continues
      s_nxt.div = s_r.div + 2'h1;
      if (s_r.div == 2'(DIV - 1)) begin
        s_nxt.div  = 2'h0;
        s_nxt.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ev.tick = s_r.tick;
endmodule

// ---- tmr_edge_det.sv ----
`timescale 1ns/1ps
module tmr_edge_det (
  input  wire logic   clock,
  input  wire logic   nrst,
  input  wire logic   cap_pin,
  input  wire logic   rising,
  tmr_evt_if.edge_src ev
);
  typedef struct packed {
    logic prev;
    logic hit;
  } tmr_ed_t;

  tmr_ed_t s_r, s_nxt;

  // edge polarity picked by the control register
  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = cap_pin;
    s_nxt.hit  = rising ? (cap_pin & ~s_r.prev) : (~cap_pin & s_r.prev);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ev.cap_edge = s_r.hit;
endmodule

// ---- tmr_top.sv ----
// How it works
// - capture edge sets the capture flag, status bit 7
// - capture flag cleared by armed status read then capture low read
// - compare equal to counter sets the compare flag, status bit 6
// - compare flag cleared by armed status read then compare low write
// - counter rolling from FFFF to 0000 sets the wrap flag, bit 5
// - wrap flag cleared by armed status read then counter low read
// - the three flags are untouched by reset
// - status register is 8 bits, flags on top, low five read zero
// - a status read arms only flags set at that moment
// - alternate counter view reads the count and never touches the wrap flag
// - wait mode keeps the timer counting and flagging
// - stop mode on processor clock freezes the counter and prescaler; capture edges still set the capture flag and register
// - on the external oscillator the timer runs in stop and wait
// - each flag requests interrupt only with its enable set
// - on the processor clock the counter advances once every four clocks; on the oscillator, once per oscillator rise
`timescale 1ns/1ps
module tmr_top (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       cap_pin,
  input  wire logic       ext_osc,
  input  wire logic       stop_mode,
  output logic            timer_irq,
  output logic            compare_out,
  output logic            osc_enable
);
  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] cnt;
    logic [2:0]  arm;
    logic        cap_inh;
    logic        cmp_inh;
    logic [7:0]  rdata;
    logic        irq;
    logic        cmp_out;
  } tmr_st_t;

  // state that reset must not disturb
  typedef struct packed {
    logic [2:0]  flags;
    logic [15:0] cap;
    logic [15:0] cmp;
  } tmr_keep_t;

  tmr_st_t   s_r, s_nxt;
  tmr_keep_t k_r, k_nxt;
  tmr_evt_if ev ();

  logic set_cap, set_cmp, set_wrap;
  logic clr_cap, clr_cmp, clr_wrap;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  tmr_clk_src #(
    .DIV (tmr_pkg::PRESCALE)
  ) u_clk (
    .clock     (clock),
    .nrst      (nrst),
    .ext_sel   (s_r.ctl[tmr_pkg::CTL_ECC]),
    .stop_mode (stop_mode),
    .ext_osc   (ext_osc),
    .ev        (ev.clk_src)
  );

  tmr_edge_det u_edge (
    .clock   (clock),
    .nrst    (nrst),
    .cap_pin (cap_pin),
    .rising  (s_r.ctl[tmr_pkg::CTL_IEDG]),
    .ev      (ev.edge_src)
  );

  // event and clearing-access decode
  always_comb begin
    set_cap  = ev.cap_edge;
    set_cmp  = ev.tick && !s_r.cmp_inh && (k_r.cmp == s_r.cnt);
    set_wrap = ev.tick && (s_r.cnt == tmr_pkg::CNT_TOP);
    clr_cap  = rd && hit(addr, tmr_pkg::OFF_CAP_LO) && s_r.arm[tmr_pkg::FLG_CAP];
    clr_cmp  = wr && hit(addr, tmr_pkg::OFF_CMP_LO) && s_r.arm[tmr_pkg::FLG_CMP];
    clr_wrap = rd && hit(addr, tmr_pkg::OFF_CNT_LO) && s_r.arm[tmr_pkg::FLG_WRAP];
  end

  // next state: counter, flags, arming, bus
  always_comb begin
    s_nxt = s_r;
    k_nxt = k_r;
    // counter only moves on the tick, so stop on the processor clock freezes it
    if (ev.tick) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    // set beats clear when both land in one cycle
    k_nxt.flags[tmr_pkg::FLG_CAP]  = set_cap  | (k_r.flags[tmr_pkg::FLG_CAP]  & ~clr_cap);
    k_nxt.flags[tmr_pkg::FLG_CMP]  = set_cmp  | (k_r.flags[tmr_pkg::FLG_CMP]  & ~clr_cmp);
    k_nxt.flags[tmr_pkg::FLG_WRAP] = set_wrap | (k_r.flags[tmr_pkg::FLG_WRAP] & ~clr_wrap);
    // a used arm is spent; a fresh status read re-arms from current flags
    if (clr_cap) begin
      s_nxt.arm[tmr_pkg::FLG_CAP] = 1'b0;
    end
    if (clr_cmp) begin
      s_nxt.arm[tmr_pkg::FLG_CMP] = 1'b0;
    end
    if (clr_wrap) begin
      s_nxt.arm[tmr_pkg::FLG_WRAP] = 1'b0;
    end
    if (rd && hit(addr, tmr_pkg::OFF_STAT)) begin
      s_nxt.arm = k_r.flags;
    end
    // capture transfer, held off between high and low byte reads
    if (ev.cap_edge && !s_r.cap_inh) begin
      k_nxt.cap = s_r.cnt;
    end
    if (rd && hit(addr, tmr_pkg::OFF_CAP_HI)) begin
      s_nxt.cap_inh = 1'b1;
    end
    if (rd && hit(addr, tmr_pkg::OFF_CAP_LO)) begin
      s_nxt.cap_inh = 1'b0;
    end
    // compare output level follows the match
    if (set_cmp) begin
      s_nxt.cmp_out = s_r.ctl[tmr_pkg::CTL_OLVL];
    end
    // register writes
    if (wr) begin
      unique case (addr)
        tmr_pkg::OFF_CTRL: s_nxt.ctl = wdata & tmr_pkg::CTL_MASK;
        tmr_pkg::OFF_CMP_HI: begin
          k_nxt.cmp[15:8] = wdata;
          s_nxt.cmp_inh   = 1'b1;
        end
        tmr_pkg::OFF_CMP_LO: begin
          k_nxt.cmp[7:0] = wdata;
          s_nxt.cmp_inh  = 1'b0;
        end
        default: ;
      endcase
    end
    // read data valid in the cycle after the strobe only
    s_nxt.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        tmr_pkg::OFF_CTRL:   s_nxt.rdata = s_r.ctl;
        tmr_pkg::OFF_STAT:   s_nxt.rdata = {k_r.flags, 5'h00};
        tmr_pkg::OFF_CAP_HI: s_nxt.rdata = k_r.cap[15:8];
        tmr_pkg::OFF_CAP_LO: s_nxt.rdata = k_r.cap[7:0];
        tmr_pkg::OFF_CMP_HI: s_nxt.rdata = k_r.cmp[15:8];
        tmr_pkg::OFF_CMP_LO: s_nxt.rdata = k_r.cmp[7:0];
        tmr_pkg::OFF_CNT_HI: s_nxt.rdata = s_r.cnt[15:8];
        tmr_pkg::OFF_CNT_LO: s_nxt.rdata = s_r.cnt[7:0];
        tmr_pkg::OFF_ALT_HI: s_nxt.rdata = s_r.cnt[15:8];
        tmr_pkg::OFF_ALT_LO: s_nxt.rdata = s_r.cnt[7:0];
        default:             s_nxt.rdata = 8'h00;
      endcase
    end
    // enable gates the request, never the flag
    s_nxt.irq = (k_r.flags[tmr_pkg::FLG_CAP]  & s_r.ctl[tmr_pkg::CTL_CAP_IE])
              | (k_r.flags[tmr_pkg::FLG_CMP]  & s_r.ctl[tmr_pkg::CTL_CMP_IE])
              | (k_r.flags[tmr_pkg::FLG_WRAP] & s_r.ctl[tmr_pkg::CTL_WRAP_IE]);
  end

  // control state with reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r     <= '0;
      s_r.ctl <= tmr_pkg::CTL_RST;
      s_r.cnt <= tmr_pkg::CNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // flags and data registers carry no reset
  always_ff @(posedge clock) begin
    k_r <= k_nxt;
  end

  assign rdata       = s_r.rdata;
  assign timer_irq   = s_r.irq;
  assign compare_out = s_r.cmp_out;
  assign osc_enable  = s_r.ctl[tmr_pkg::CTL_EOE];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence arm_cap_s;
    rd && hit(addr, tmr_pkg::OFF_STAT) && k_r.flags[tmr_pkg::FLG_CAP];
  endsequence
  sequence take_cap_s;
    rd && hit(addr, tmr_pkg::OFF_CAP_LO) && !ev.cap_edge;
  endsequence
  sequence arm_wrap_s;
    rd && hit(addr, tmr_pkg::OFF_STAT) && k_r.flags[tmr_pkg::FLG_WRAP];
  endsequence
  sequence take_wrap_s;
    rd && hit(addr, tmr_pkg::OFF_CNT_LO) && !set_wrap;
  endsequence

  cap_set_a: assert property (ev.cap_edge |=> k_r.flags[tmr_pkg::FLG_CAP])
    else $error("capture edge did not set flag");
  cap_clear_a: assert property (arm_cap_s ##1 take_cap_s |=> !k_r.flags[tmr_pkg::FLG_CAP])
    else $error("capture flag not cleared");
  cap_hold_a: assert property (k_r.flags[tmr_pkg::FLG_CAP] && !s_r.arm[tmr_pkg::FLG_CAP]
                               |=> k_r.flags[tmr_pkg::FLG_CAP])
    else $error("unarmed capture flag dropped");
  cmp_set_a: assert property (ev.tick && !s_r.cmp_inh && k_r.cmp == s_r.cnt
                              |=> k_r.flags[tmr_pkg::FLG_CMP])
    else $error("compare match did not set flag");
  cmp_clear_a: assert property (wr && hit(addr, tmr_pkg::OFF_CMP_LO) && s_r.arm[tmr_pkg::FLG_CMP]
                                && !set_cmp |=> !k_r.flags[tmr_pkg::FLG_CMP])
    else $error("compare flag not cleared");
  wrap_set_a: assert property (ev.tick && s_r.cnt == tmr_pkg::CNT_TOP
                               |=> k_r.flags[tmr_pkg::FLG_WRAP] && s_r.cnt == 16'h0000)
    else $error("wrap did not set flag");
  wrap_clear_a: assert property (arm_wrap_s ##1 take_wrap_s |=> !k_r.flags[tmr_pkg::FLG_WRAP])
    else $error("wrap flag not cleared");
  // flags power up unknown and are never reset, so these compares use case equality
  stat_read_a: assert property (rd && hit(addr, tmr_pkg::OFF_STAT)
                                |=> rdata === {$past(k_r.flags), 5'h00})
    else $error("status read data wrong");
  arm_take_a: assert property (rd && hit(addr, tmr_pkg::OFF_STAT)
                               |=> s_r.arm === $past(k_r.flags))
    else $error("arming does not match flags");
  alt_keep_a: assert property (k_r.flags[tmr_pkg::FLG_WRAP] && rd && hit(addr, tmr_pkg::OFF_ALT_LO)
                               |=> k_r.flags[tmr_pkg::FLG_WRAP])
    else $error("alternate read touched wrap flag");
  stop_freeze_a: assert property (stop_mode && !s_r.ctl[tmr_pkg::CTL_ECC] && $stable(stop_mode)
                                  && !ev.tick |=> !ev.tick && $stable(s_r.cnt))
    else $error("counter moved in stop");
  tick_gap_a: assert property (ev.tick && !s_r.ctl[tmr_pkg::CTL_ECC] |=> !ev.tick [*3])
    else $error("prescaler faster than four");
  irq_or_a: assert property (##1 timer_irq === $past(|(k_r.flags & {s_r.ctl[tmr_pkg::CTL_CAP_IE],
                             s_r.ctl[tmr_pkg::CTL_CMP_IE], s_r.ctl[tmr_pkg::CTL_WRAP_IE]})))
    else $error("interrupt not OR of enabled flags");

  // internal source: one tick in every four clocks, wait mode included
  sequence tick_run_s;
    ev.tick && !stop_mode && !s_r.ctl[tmr_pkg::CTL_ECC]
      ##1 (!stop_mode && !s_r.ctl[tmr_pkg::CTL_ECC]) [*3];
  endsequence
  // oscillator source: a rise becomes a tick one cycle on, stop or not
  sequence osc_rise_s;
    s_r.ctl[tmr_pkg::CTL_ECC] && $rose(ext_osc);
  endsequence

  tick_four_a: assert property (tick_run_s |=> ev.tick)
    else $error("internal tick not every fourth clock");
  osc_tick_a: assert property (osc_rise_s |=> ev.tick)
    else $error("oscillator rise gave no tick");
  cnt_step_a: assert property (ev.tick |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("counter did not step on tick");
  cnt_still_a: assert property (!ev.tick |=> $stable(s_r.cnt))
    else $error("counter moved without tick");

  // capture copies the count of the edge cycle unless held off
  cap_take_a: assert property (ev.cap_edge && !s_r.cap_inh
                               |=> k_r.cap == $past(s_r.cnt))
    else $error("capture register missed the count");

  // compare output level, flags that must wait for their own arm, and wrap flag set only by rollover
  cmp_out_a: assert property (set_cmp
                              |=> compare_out == $past(s_r.ctl[tmr_pkg::CTL_OLVL]))
    else $error("compare output did not take level");
  cmp_hold_a: assert property (k_r.flags[tmr_pkg::FLG_CMP] && !s_r.arm[tmr_pkg::FLG_CMP]
                               |=> k_r.flags[tmr_pkg::FLG_CMP])
    else $error("unarmed compare flag dropped");
  wrap_hold_a: assert property (k_r.flags[tmr_pkg::FLG_WRAP] && !s_r.arm[tmr_pkg::FLG_WRAP]
                                |=> k_r.flags[tmr_pkg::FLG_WRAP])
    else $error("unarmed wrap flag dropped");
  wrap_only_a: assert property (!k_r.flags[tmr_pkg::FLG_WRAP] && !set_wrap
                                |=> !k_r.flags[tmr_pkg::FLG_WRAP])
    else $error("wrap flag set without rollover");

  // no enable, no request, whatever the flags hold
  irq_off_a: assert property (!s_r.ctl[tmr_pkg::CTL_CAP_IE] && !s_r.ctl[tmr_pkg::CTL_CMP_IE]
                              && !s_r.ctl[tmr_pkg::CTL_WRAP_IE] |=> !timer_irq)
    else $error("interrupt raised with enables clear");

  // alternate view returns the live count; read data only after a strobe
  alt_lo_a: assert property (rd && hit(addr, tmr_pkg::OFF_ALT_LO)
                             |=> rdata == $past(s_r.cnt[7:0]))
    else $error("alternate low byte wrong");
  alt_hi_a: assert property (rd && hit(addr, tmr_pkg::OFF_ALT_HI)
                             |=> rdata == $past(s_r.cnt[15:8]))
    else $error("alternate high byte wrong");
  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without a read strobe");
endmodule

// ---- timer_status_flag_logic_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module timer_status_flag_logic_tb;
  logic        clock;
  logic        nrst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        cap_pin;
  logic        ext_osc;
  logic        stop_mode;
  logic        timer_irq;
  logic        compare_out;
  logic        osc_enable;
  logic        osc_run;
  logic [7:0]  d;
  logic [7:0]  g;
  logic [15:0] c;
  logic [15:0] t;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;

  tmr_top dut_u (
    .clock       (clock),
    .nrst        (nrst),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rdata       (rdata),
    .cap_pin     (cap_pin),
    .ext_osc     (ext_osc),
    .stop_mode   (stop_mode),
    .timer_irq   (timer_irq),
    .compare_out (compare_out),
    .osc_enable  (osc_enable)
  );

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // external oscillator runs at half the clock, one rise every two cycles
  always @(posedge clock) begin
    if (osc_run) begin
      ext_osc <= ~ext_osc;
    end
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  task stop_test;
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task rd_reg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task rd_cnt;
    rd_reg(tmr_pkg::OFF_ALT_HI);
    c[15:8] = d;
    rd_reg(tmr_pkg::OFF_ALT_LO);
    c[7:0] = d;
  endtask

  // two low-byte reads taken exactly 40 cycles apart
  task cnt_gap;
    rd_reg(tmr_pkg::OFF_ALT_LO);
    g = d;
    repeat (38) @(posedge clock);
    rd_reg(tmr_pkg::OFF_ALT_LO);
    g = d - g;
  endtask

  task t_regs;
    rd_reg(tmr_pkg::OFF_CTRL);
    `CHK(d, tmr_pkg::CTL_RST)
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[4:0], 5'h00)
    rd_reg(8'h00);
    `CHK(d, 8'h00)
    `CHK(compare_out, 1'b0)
    wr_reg(tmr_pkg::OFF_CTRL, 8'hFF);
    rd_reg(tmr_pkg::OFF_CTRL);
    `CHK(d, tmr_pkg::CTL_MASK)
    `CHK(osc_enable, 1'b1)
    wr_reg(tmr_pkg::OFF_STAT, 8'h00);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[4:0], 5'h00)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h00);
  endtask

  task t_count;
    cnt_gap();
    `CHK(g, 8'h0A)
  endtask

  task t_stop;
    stop_mode <= 1'b1;
    cnt_gap();
    `CHK(g, 8'h00)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h08);
    osc_run <= 1'b1;
    cnt_gap();
    `CHK(g, 8'h14)
    stop_mode <= 1'b0;
    cnt_gap();
    `CHK(g, 8'h14)
    osc_run <= 1'b0;
    wr_reg(tmr_pkg::OFF_CTRL, 8'h00);
    cnt_gap();
    `CHK(g, 8'h0A)
  endtask

  task t_cap;
    wr_reg(tmr_pkg::OFF_CTRL, 8'h02);
    rd_reg(tmr_pkg::OFF_ALT_LO);
    c[7:0] = d;
    @(posedge clock);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[7], 1'b1)
    rd_reg(tmr_pkg::OFF_CAP_HI);
    rd_reg(tmr_pkg::OFF_CAP_LO);
    `CHK((d - c[7:0]) & 8'hFE, 8'h00)
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[7], 1'b0)
    cap_pin <= 1'b0;
    repeat (4) @(posedge clock);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[7], 1'b0)
    cap_pin <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(tmr_pkg::OFF_CAP_LO);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[7], 1'b1)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h82);
    repeat (2) @(posedge clock);
    `CHK(timer_irq, 1'b1)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h00);
  endtask

  // compare flag starts unknown, so a real match comes before any clearing
  task t_cmp;
    wr_reg(tmr_pkg::OFF_CTRL, 8'h41);
    rd_cnt();
    t = c + 16'h0014;
    wr_reg(tmr_pkg::OFF_CMP_HI, t[15:8]);
    wr_reg(tmr_pkg::OFF_CMP_LO, t[7:0]);
    repeat (100) @(posedge clock);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[6], 1'b1)
    `CHK(compare_out, 1'b1)
    `CHK(timer_irq, 1'b1)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(timer_irq, 1'b0)
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[6], 1'b1)
    wr_reg(tmr_pkg::OFF_CMP_LO, t[7:0]);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[6], 1'b0)
    wr_reg(tmr_pkg::OFF_CTRL, 8'h00);
    rd_cnt();
    t = c + 16'h0014;
    wr_reg(tmr_pkg::OFF_CMP_HI, t[15:8]);
    wr_reg(tmr_pkg::OFF_CMP_LO, t[7:0]);
    rd_reg(tmr_pkg::OFF_STAT);
    repeat (100) @(posedge clock);
    `CHK(compare_out, 1'b0)
    wr_reg(tmr_pkg::OFF_CMP_LO, t[7:0]);
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[6], 1'b1)
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd_reg(tmr_pkg::OFF_STAT);
    `CHK(d[6], 1'b1)
    rd_reg(tmr_pkg::OFF_CTRL);
    `CHK(d, tmr_pkg::CTL_RST)
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cap_pin = 1'b0;
    ext_osc = 1'b0;
    stop_mode = 1'b0;
    osc_run = 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_count();
    t_stop();
    t_cap();
    t_cmp();
    stop_test();
  end
endmodule
